/* File: rtl/fkl_flash_key_lock.sv */
// Functional notes
// - Writes allowed only after first then second key.
// - Permission revoked after one write or erase.
// - Out-of-sequence key write locks until reset.
// - Write or erase while locked locks until reset.
// - Key read returns two-bit lock state.
// - Key register at 0xB7, every page.
// - Timing register at 0xB6, every page.
// - Read strobe one or two clocks by bit.
// - Timing bit selects short or extended timing.
// - Write enable steers external write to flash.
// - Write plus erase enable erases whole page.
`timescale 1ns/1ps
`default_nettype none

module fkl_flash_key_lock (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // Special function register bus
  input  wire logic [7:0]                sfr_addr,
  input  wire logic [7:0]                sfr_wdata,
  input  wire logic                      sfr_wr,
  input  wire logic                      sfr_rd,
  output logic [7:0]                     sfr_rdata,
  output logic                           sfr_hit,
  // Program store control bits from the core
  input  wire logic                      program_store_write_enable,
  input  wire logic                      page_erase_enable,
  // External move write from the core
  input  wire logic                      ext_wr,
  input  wire logic [fkl_pkg::ADDR_W-1:0] ext_addr,
  input  wire logic [fkl_pkg::DATA_W-1:0] ext_data,
  output logic                           flash_busy,
  // External data memory write
  output logic                           xram_wr,
  output logic [fkl_pkg::ADDR_W-1:0]     xram_addr,
  output logic [fkl_pkg::DATA_W-1:0]     xram_data,
  // Flash program and erase
  output logic                           flash_wr_start,
  output logic                           flash_erase_start,
  output logic [fkl_pkg::ADDR_W-1:0]     flash_addr,
  output logic [fkl_pkg::DATA_W-1:0]     flash_wdata,
  output logic                           erase_write_time_extend,
  input  wire logic                      flash_op_done,
  // Flash read
  input  wire logic                      rd_req,
  input  wire logic [fkl_pkg::ADDR_W-1:0] rd_addr,
  output logic                           rd_ready,
  output logic                           flash_rd_strobe,
  output logic [fkl_pkg::ADDR_W-1:0]     flash_rd_addr,
  // Lock state for observation
  output logic [1:0]                     lock_code
);

  // Whole state of the block
  // One register bank; the next value is built in one place
  typedef struct packed {
    // Lock and timing
    fkl_pkg::fkl_lock_t           lock;     // Lock state
    logic [7:0]                   timing;   // Timing scale register

    // Flash operation and data memory write
    logic                         busy;     // Flash operation running
    logic                         wr_go;    // Program start pulse
    logic                         er_go;    // Erase start pulse
    logic                         xwr;      // Data memory write pulse
    logic [fkl_pkg::ADDR_W-1:0]   addr;     // Operation address
    logic [fkl_pkg::DATA_W-1:0]   data;     // Operation data

    // Register read answer
    logic [7:0]                   rdata;    // Register read data
    logic                         hit;      // Read hit a register
  } fkl_state_t;

  // Registered state and its next value
  fkl_state_t cur;
  fkl_state_t next_cur;

  // Lock state to its readable two-bit code
  // Shared by the read path and the lock_code port
  function automatic logic [1:0] lock_to_code(input fkl_pkg::fkl_lock_t s);
    case (s)
      fkl_pkg::LK_LOCKED:   lock_to_code = fkl_pkg::CODE_LOCKED;
      fkl_pkg::LK_KEY1:     lock_to_code = fkl_pkg::CODE_KEY1;
      fkl_pkg::LK_UNLOCKED: lock_to_code = fkl_pkg::CODE_UNLOCKED;
      // Unknown codes read as disabled, the safe side
      default:              lock_to_code = fkl_pkg::CODE_DISABLED;
    endcase
  endfunction

  // Register address match; page select does not matter
  // Both registers sit on every page, so no page term
  function automatic logic sfr_match(input logic [7:0] a,
                                     input logic [7:0] reg_addr);
    sfr_match = (a == reg_addr);
  endfunction

  // Key write effect on the lock state
  // Pure function of the old state and the byte
  // Completion and refused writes are handled by the caller
  function automatic fkl_pkg::fkl_lock_t key_step(
      input fkl_pkg::fkl_lock_t s, input logic [7:0] key);
    case (s)
      fkl_pkg::LK_LOCKED: begin
        // First key opens the sequence, anything else locks
        if (key == fkl_pkg::KEY_FIRST) begin
          key_step = fkl_pkg::LK_KEY1;
        end else begin
          // Second key too early lands here as well
          key_step = fkl_pkg::LK_DISABLED;
        end
      end
      fkl_pkg::LK_KEY1: begin
        // Second key must follow at once
        if (key == fkl_pkg::KEY_SECOND) begin
          key_step = fkl_pkg::LK_UNLOCKED;
        end else begin
          // Anything but the second key is misuse
          key_step = fkl_pkg::LK_DISABLED;
        end
      end
      default: begin
        // Any key write when unlocked or disabled is misuse
        key_step = fkl_pkg::LK_DISABLED;
      end
    endcase
  endfunction

  // Read strobe one-shot
  // Length bit taken straight from the timing register
  // A change applies from the next request on
  // Requests during a strobe are dropped inside
  fkl_read_strobe u_read_strobe (
    .mclk               (mclk),
    .rst                (rst),
    .rd_req             (rd_req),
    .rd_addr            (rd_addr),
    .read_strobe_length (cur.timing[fkl_pkg::READ_STROBE_BIT]),
    .rd_ready           (rd_ready),
    .flash_rd_strobe    (flash_rd_strobe),
    .flash_rd_addr      (flash_rd_addr)
  );

  // Next state
  // Blocks run in a fixed order; later ones win on the lock
  // Order: completion, register write, external write, read, hold
  // Pulses are cleared first so each lasts one clock
  always_comb begin
    // Hold by default
    next_cur       = cur;
    // Start and write pulses drop unless set below
    next_cur.wr_go = 1'b0;
    next_cur.er_go = 1'b0;
    next_cur.xwr   = 1'b0;

    // Completion of the single allowed operation relocks
    // Done only counts while an operation runs
    // A stray pulse from the array therefore does nothing
    if (cur.busy && flash_op_done) begin
      // Array free again
      next_cur.busy = 1'b0;
      if (cur.lock == fkl_pkg::LK_UNLOCKED) begin
        // One operation per unlock
        next_cur.lock = fkl_pkg::LK_LOCKED;
      end
      // Disabled during the operation stays disabled
    end

    // Register writes
    // Key step uses the state before this clock
    // So a key write in the completion cycle still counts
    // as a write while unlocked, and disables the array
    if (sfr_wr) begin
      if (sfr_match(sfr_addr, fkl_pkg::SFR_ADDR_KEY)) begin
        // Key register, reached from any page
        next_cur.lock = key_step(cur.lock, sfr_wdata);
      end else if (sfr_match(sfr_addr, fkl_pkg::SFR_ADDR_TIMING)) begin
        // Timing register, reached from any page
        // All eight bits kept, reserved ones too
        next_cur.timing = sfr_wdata;
      end
      // Other addresses belong to other blocks
    end

    // External move write
    // Write enable low: ordinary data memory write, never refused
    // Write enable high: the flash is the target
    // A flash request while busy is dropped without effect
    if (ext_wr) begin
      if (!program_store_write_enable) begin
        // Plain data memory write
        // Address and data register shared with the flash side
        next_cur.xwr  = 1'b1;
        next_cur.addr = ext_addr;
        next_cur.data = ext_data;
      end else if (!cur.busy) begin
        if (cur.lock == fkl_pkg::LK_UNLOCKED) begin
          // Steered to flash: page erase or byte write
          next_cur.busy  = 1'b1;
          next_cur.addr  = ext_addr;
          // Data byte is ignored by an erase
          next_cur.data  = ext_data;
          // Erase enable turns the write into a page erase
          next_cur.er_go = page_erase_enable;
          next_cur.wr_go = !page_erase_enable;
        end else begin
          // Attempt without permission locks until reset
          // No start pulse reaches the array
          next_cur.lock = fkl_pkg::LK_DISABLED;
        end
      end
    end

    // Register reads, answered next cycle
    // Data is zero unless a mapped register was read
    // Lets the core merge read buses of many blocks
    next_cur.hit   = 1'b0;
    next_cur.rdata = fkl_pkg::RDATA_RESET;
    if (sfr_rd) begin
      if (sfr_match(sfr_addr, fkl_pkg::SFR_ADDR_KEY)) begin
        // Lock state in the two low bits, the rest zero
        // Shows the state before a same-cycle write
        next_cur.hit   = 1'b1;
        next_cur.rdata = {6'h00, lock_to_code(cur.lock)};
      end else if (sfr_match(sfr_addr, fkl_pkg::SFR_ADDR_TIMING)) begin
        // Timing register as written
        // Reserved bits read back too
        next_cur.hit   = 1'b1;
        next_cur.rdata = cur.timing;
      end
    end

    // Disabled is never left without reset
    // Last in the block so nothing above can undo it
    if (cur.lock == fkl_pkg::LK_DISABLED) begin
      next_cur.lock = fkl_pkg::LK_DISABLED;
    end
  end

  // State register
  // Synchronous reset puts every field to its idle value
  // Lock state always comes back as locked
  always_ff @(posedge mclk) begin
    if (rst) begin
      // Locked, whatever the state before
      cur.lock   <= fkl_pkg::LK_LOCKED;
      // Timing back to its reset value
      cur.timing <= fkl_pkg::TIMING_RESET;
      // No operation in flight, no pulses
      cur.busy   <= 1'b0;
      cur.wr_go  <= 1'b0;
      cur.er_go  <= 1'b0;
      cur.xwr    <= 1'b0;
      // Address and data cleared
      cur.addr   <= '0;
      cur.data   <= '0;
      // Read answer cleared
      cur.rdata  <= fkl_pkg::RDATA_RESET;
      cur.hit    <= 1'b0;
    end else begin
      // Take the next value
      cur <= next_cur;
    end
  end

  // Outputs
  // Register fields, or plain decodes of them
  // Register read side
  assign sfr_rdata         = cur.rdata;
  assign sfr_hit           = cur.hit;

  // Write handshake with the core
  assign flash_busy        = cur.busy;

  // Data memory write; shares the address and data register
  assign xram_wr           = cur.xwr;
  assign xram_addr         = cur.addr;
  assign xram_data         = cur.data;

  // Flash program and erase requests
  assign flash_wr_start    = cur.wr_go;
  assign flash_erase_start = cur.er_go;
  assign flash_addr        = cur.addr;
  assign flash_wdata       = cur.data;

  // Lock state for observation, same code as a key read
  assign lock_code         = lock_to_code(cur.lock);

  // Extended or short program and erase timing
  // Only passed on; the array owns the actual timing
  // Software sets it before any write or erase
  assign erase_write_time_extend =
    cur.timing[fkl_pkg::EXTEND_BIT];

endmodule

`default_nettype wire

/* File: rtl/fkl_pkg.sv */
package fkl_pkg;

  // Register addresses on the special function register bus
  localparam logic [7:0] SFR_ADDR_TIMING = 8'hb6;
  localparam logic [7:0] SFR_ADDR_KEY    = 8'hb7;

  // Reset values
  localparam logic [7:0] TIMING_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET  = 8'h00;

  // Key codes
  localparam logic [7:0] KEY_FIRST  = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;

  // Field positions in the timing register
  localparam int READ_STROBE_BIT = 4;
  localparam int EXTEND_BIT      = 1;

  // Lock state codes as read back from the key register
  localparam logic [1:0] CODE_LOCKED   = 2'h0;
  localparam logic [1:0] CODE_KEY1     = 2'h1;
  localparam logic [1:0] CODE_UNLOCKED = 2'h2;
  localparam logic [1:0] CODE_DISABLED = 2'h3;

  // Read strobe lengths in core clocks
  localparam int STROBE_SHORT = 1;
  localparam int STROBE_LONG  = 2;

  // Flash address and data widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Lock state machine, one-hot
  typedef enum logic [3:0] {
    LK_LOCKED   = 4'b0001,
    LK_KEY1     = 4'b0010,
    LK_UNLOCKED = 4'b0100,
    LK_DISABLED = 4'b1000
  } fkl_lock_t;

  // Read strobe generator state
  typedef enum logic [1:0] {
    RS_IDLE   = 2'b01,
    RS_STROBE = 2'b10
  } fkl_rs_t;

endpackage

/* File: rtl/fkl_read_strobe.sv */
`timescale 1ns/1ps
`default_nettype none

// Flash read strobe one-shot: one or two core clocks long
module fkl_read_strobe (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // Read request from the core
  input  wire logic                      rd_req,
  input  wire logic [fkl_pkg::ADDR_W-1:0] rd_addr,
  input  wire logic                      read_strobe_length,
  output logic                           rd_ready,
  // Towards the flash array
  output logic                           flash_rd_strobe,
  output logic [fkl_pkg::ADDR_W-1:0]     flash_rd_addr
);

  typedef struct packed {
    fkl_pkg::fkl_rs_t            st;    // Strobe state
    logic                        left;  // Extra cycle still owed
    logic                        strobe; // Registered strobe
    logic [fkl_pkg::ADDR_W-1:0]  addr;  // Latched read address
  } fkl_rs_state_t;

  fkl_rs_state_t cur;
  fkl_rs_state_t next_cur;

  // Extra cycles beyond the first for a given length
  function automatic logic extra_cycle(input logic long_sel);
    extra_cycle = long_sel
      ? ((fkl_pkg::STROBE_LONG - fkl_pkg::STROBE_SHORT) > 0)
      : 1'b0;
  endfunction

  // Next state
  always_comb begin
    next_cur = cur;
    case (cur.st)
      fkl_pkg::RS_IDLE: begin
        // Start a strobe; length follows the timing bit
        if (rd_req) begin
          next_cur.st     = fkl_pkg::RS_STROBE;
          next_cur.strobe = 1'b1;
          next_cur.left   = extra_cycle(read_strobe_length);
          next_cur.addr   = rd_addr;
        end
      end
      fkl_pkg::RS_STROBE: begin
        // Hold for the owed cycle, then release
        if (cur.left) begin
          next_cur.left = 1'b0;
        end else begin
          next_cur.st     = fkl_pkg::RS_IDLE;
          next_cur.strobe = 1'b0;
        end
      end
      default: begin
        next_cur.st     = fkl_pkg::RS_IDLE;
        next_cur.strobe = 1'b0;
        next_cur.left   = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur.st     <= fkl_pkg::RS_IDLE;
      cur.left   <= 1'b0;
      cur.strobe <= 1'b0;
      cur.addr   <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs
  assign flash_rd_strobe = cur.strobe;
  assign flash_rd_addr   = cur.addr;
  assign rd_ready        = cur.strobe && !cur.left;

endmodule

`default_nettype wire

/* File: bench/fkl_lock_props.sv */
`timescale 1ns/1ps
`default_nettype none

// Port checker for the key lock block
module fkl_lock_props (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_hit,
  // Flash write side
  input wire logic       program_store_write_enable,
  input wire logic       page_erase_enable,
  input wire logic       ext_wr,
  input wire logic       flash_busy,
  input wire logic       flash_wr_start,
  input wire logic       flash_erase_start,
  input wire logic       erase_write_time_extend,
  input wire logic       flash_op_done,
  // Read strobe and state
  input wire logic       rd_req,
  input wire logic       rd_ready,
  input wire logic       flash_rd_strobe,
  input wire logic [1:0] lock_code
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Key write and its legality
  logic kw;
  logic ok;
  logic ew;
  assign kw = sfr_wr && sfr_addr == fkl_pkg::SFR_ADDR_KEY;
  assign ok = (lock_code == 2'h0 && sfr_wdata == fkl_pkg::KEY_FIRST)
    || (lock_code == 2'h1 && sfr_wdata == fkl_pkg::KEY_SECOND);
  assign ew = ext_wr && program_store_write_enable && !flash_busy;

  // Read strobe length bit as last written
  logic strobe_long;
  always_ff @(posedge mclk) begin
    if (rst) begin
      strobe_long <= 1'b0;
    end else if (sfr_wr && sfr_addr == fkl_pkg::SFR_ADDR_TIMING) begin
      strobe_long <= sfr_wdata[fkl_pkg::READ_STROBE_BIT];
    end
  end

  // Strobe shapes
  sequence s_short;
    flash_rd_strobe && rd_ready ##1 !flash_rd_strobe;
  endsequence
  sequence s_long;
    flash_rd_strobe && !rd_ready ##1 flash_rd_strobe && rd_ready
      ##1 !flash_rd_strobe;
  endsequence

  property p_key;
    kw && ok |=> lock_code == $past(lock_code) + 2'h1;
  endproperty
  a_key: assert property (p_key) else $error("key step wrong");
  property p_bad;
    kw && !ok |=> lock_code == 2'h3;
  endproperty
  a_bad: assert property (p_bad) else $error("bad key kept");
  property p_hold;
    lock_code == 2'h3 |=> lock_code == 2'h3;
  endproperty
  a_hold: assert property (p_hold) else $error("left lock");
  property p_deny;
    ew && lock_code != 2'h2
      |=> lock_code == 2'h3 && !flash_wr_start && !flash_erase_start;
  endproperty
  a_deny: assert property (p_deny) else $error("denied op");
  property p_go;
    ew && lock_code == 2'h2 |=> flash_busy
      && flash_erase_start == $past(page_erase_enable)
      && flash_wr_start != $past(page_erase_enable);
  endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_relock;
    flash_busy && flash_op_done && lock_code == 2'h2 && !kw
      |=> !flash_busy && lock_code == 2'h0;
  endproperty
  a_relock: assert property (p_relock) else $error("no relock");
  property p_rd;
    sfr_rd && sfr_addr == fkl_pkg::SFR_ADDR_KEY
      |=> sfr_hit && sfr_rdata == {6'h0, $past(lock_code)};
  endproperty
  a_rd: assert property (p_rd) else $error("key read");
  property p_ext;
    sfr_wr && sfr_addr == fkl_pkg::SFR_ADDR_TIMING
      |=> erase_write_time_extend == $past(sfr_wdata[1]);
  endproperty
  a_ext: assert property (p_ext) else $error("extend bit");
  property p_strb;
    rd_req && !flash_rd_strobe && !strobe_long |=> s_short;
  endproperty
  a_strb: assert property (p_strb) else $error("strobe");
  property p_strb_long;
    rd_req && !flash_rd_strobe && strobe_long |=> s_long;
  endproperty
  a_strb_long: assert property (p_strb_long) else $error("long");
endmodule

bind fkl_flash_key_lock fkl_lock_props u_props (.mclk, .rst, .sfr_addr,
  .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .sfr_hit,
  .program_store_write_enable, .page_erase_enable, .ext_wr, .flash_busy,
  .flash_wr_start, .flash_erase_start, .erase_write_time_extend,
  .flash_op_done, .rd_req, .rd_ready, .flash_rd_strobe, .lock_code);
`default_nettype wire

/* File: bench/fkl_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Flash array: answers each started op after a chosen delay
module fkl_flash_model (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Op starts and answer
  input wire logic       wr_start,
  input wire logic       erase_start,
  input wire logic [3:0] delay,
  output logic           op_done
);
  logic [3:0] cnt; // Cycles left
  logic       busy; // Op in flight
  // Done is a single pulse, low at all other times
  always_ff @(posedge mclk) begin
    op_done <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
    end else if (wr_start || erase_start) begin
      busy <= 1'b1;
      cnt <= delay;
    end else if (busy && cnt == 4'h0) begin
      busy <= 1'b0;
      op_done <= 1'b1;
    end else begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_flash_key_lock.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_flash_key_lock;
  logic mclk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, ext_wr = 0, rd_req = 0;
  logic program_store_write_enable = 0, page_erase_enable = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, ext_data = 0, sfr_rdata;
  logic [7:0] xram_data, flash_wdata;
  logic [15:0] ext_addr = 0, rd_addr = 0, xram_addr, flash_addr;
  logic [15:0] flash_rd_addr;
  logic sfr_hit, flash_busy, xram_wr, flash_wr_start, flash_erase_start;
  logic erase_write_time_extend, flash_op_done, rd_ready, flash_rd_strobe;
  logic [1:0] lock_code, code = 0;
  logic [3:0] delay = 0;
  logic [31:0] lfsr = 32'h4d5d_0b6d;
  int num_errors = 0, checked = 0, cyc = 0;
  localparam logic [7:0] KA = fkl_pkg::SFR_ADDR_KEY;

  always #2.5 mclk = ~mclk;

  fkl_flash_key_lock uut (.mclk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_rd, .sfr_rdata, .sfr_hit, .program_store_write_enable,
    .page_erase_enable, .ext_wr, .ext_addr, .ext_data, .flash_busy,
    .xram_wr, .xram_addr, .xram_data, .flash_wr_start, .flash_erase_start,
    .flash_addr, .flash_wdata, .erase_write_time_extend, .flash_op_done,
    .rd_req, .rd_addr, .rd_ready, .flash_rd_strobe, .flash_rd_addr,
    .lock_code);
  fkl_flash_model u_flash (.mclk, .rst, .wr_start(flash_wr_start),
    .erase_start(flash_erase_start), .delay, .op_done(flash_op_done));

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  // Next value of the stimulus shift register
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic nr;
    lfsr = lfsr_step(lfsr);
  endtask
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Expected lock state after a key write
  function automatic logic [1:0] nxt(input logic [1:0] c, input logic [7:0] d);
    if (c == 2'h0 && d == fkl_pkg::KEY_FIRST) return 2'h1;
    if (c == 2'h1 && d == fkl_pkg::KEY_SECOND) return 2'h2;
    return 2'h3;
  endfunction
  task automatic wr(input logic [7:0] a, d);
    tick;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    tick;
    sfr_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    tick;
    sfr_addr = a;
    sfr_rd = 1;
    tick;
    sfr_rd = 0;
    chk({sfr_hit, sfr_rdata}, {a[7:1] == 7'h5b, e});
  endtask
  task automatic wk(input logic [7:0] d);
    wr(KA, d);
    code = nxt(code, d);
    rd(KA, {6'h0, code});
    chk(lock_code, code);
  endtask
  task automatic rs;
    tick;
    rst = 1;
    tick;
    rst = 0;
    code = 0;
    rd(KA, 8'h00);
  endtask
  // One external write: data memory, flash op or refused op
  task automatic xw(input logic we, pe);
    tick;
    nr;
    program_store_write_enable = we;
    page_erase_enable = pe;
    ext_addr = lfsr[15:0];
    ext_data = lfsr[23:16];
    ext_wr = 1;
    tick;
    ext_wr = 0;
    if (!we) chk(xram_data, ext_data);
    if (!we) chk({xram_wr, xram_addr}, {1'b1, ext_addr});
    else begin
      chk({flash_wr_start, flash_erase_start}, code == 2 ? {~pe, pe} : 0);
      if (code == 2'h2) begin
        chk({flash_addr, flash_wdata}, {ext_addr, ext_data});
        for (int i = 0; i < 40 && flash_busy; i++) tick;
        chk(flash_busy, 0);
        code = 0;
      end else code = 3;
      rd(KA, {6'h0, code});
    end
  endtask
  // Strobe length per timing bit; also sets and checks the extend bit
  task automatic strobe(input logic lng);
    logic [23:0] n;
    wr(fkl_pkg::SFR_ADDR_TIMING, {3'h0, lng, 2'h0, 2'h2});
    rd(fkl_pkg::SFR_ADDR_TIMING, {3'h0, lng, 2'h0, 2'h2});
    chk(erase_write_time_extend, 1);
    nr;
    rd_addr = lfsr[15:0];
    rd_req = 1;
    tick;
    rd_req = 0;
    chk(flash_rd_addr, rd_addr);
    n = 0;
    while (flash_rd_strobe && n < 5) begin
      n++;
      chk(rd_ready, n == (lng ? 24'h2 : 24'h1));
      tick;
    end
    chk(n, lng ? 24'h2 : 24'h1);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done;
    end
  end

  initial begin
    repeat (10) tick;
    rst = 0;
    rd(fkl_pkg::SFR_ADDR_TIMING, 8'h00);
    chk(erase_write_time_extend, 0);
    rd(KA, 8'h00);
    rd(8'hb5, 8'h00);
    strobe(0);
    strobe(1);
    wk(fkl_pkg::KEY_SECOND);
    rs;
    // Unlock, one op (refused on the last pass after a stray key), data write, then a refused op
    for (int k = 0; k < 4; k++) begin
      nr;
      delay = k[0] ? lfsr[3:0] : 4'h0;
      wk(fkl_pkg::KEY_FIRST);
      wk(fkl_pkg::KEY_SECOND);
      if (k == 3) wk(lfsr[7:0]);
      xw(1, k[1]);
      xw(0, 0);
      xw(1, 0);
      rs;
    end
    // Random key sequences, deliberate locking among them
    for (int k = 0; k < 8; k++) begin
      nr;
      wk(k[0] ? fkl_pkg::KEY_FIRST : lfsr[7:0]);
      wk(lfsr[15:8]);
      wk(k[1] ? fkl_pkg::KEY_SECOND : fkl_pkg::KEY_FIRST);
      rs;
    end
    test_done;
  end
endmodule
`default_nettype wire
